// ---- hw/ufl_pkg.sv ----
// Purpose: shared constants for the uart fifo/line/modem control block
// Assumes: 8-bit register port, 3-bit register index
// Notes:   register indices are the printed offsets
package ufl_pkg;
  // register indices
  localparam logic [2:0] UFL_IDX_DATA  = 3'h0;
  localparam logic [2:0] UFL_IDX_DIVHI = 3'h1;
  localparam logic [2:0] UFL_IDX_FIFO  = 3'h2;
  localparam logic [2:0] UFL_IDX_FRAC  = 3'h2;
  localparam logic [2:0] UFL_IDX_FMT   = 3'h3;
  localparam logic [2:0] UFL_IDX_MODEM = 3'h4;
  localparam logic [2:0] UFL_IDX_STAT6 = 3'h6;
  localparam logic [2:0] UFL_IDX_STAT7 = 3'h7;
  // reset values
  localparam logic [7:0] UFL_FMT_RST   = 8'h1D;
  localparam logic [7:0] UFL_MODEM_RST = 8'h00;
  localparam logic [7:0] UFL_SCR_RST   = 8'hFF;
  localparam logic [7:0] UFL_ZERO      = 8'h00;
  // field positions
  localparam int UFL_FIFO_EN  = 0;
  localparam int UFL_RX_RST   = 1;
  localparam int UFL_TX_RST   = 2;
  localparam int UFL_BREAK    = 6;
  localparam int UFL_DIV_SEL  = 7;
  localparam int UFL_PAR_EN   = 3;
  localparam int UFL_PAR_EVEN = 4;
  localparam int UFL_PAR_FRC  = 5;
  localparam int UFL_STOP     = 2;
  localparam int UFL_LOOP     = 4;
  // fifo reset hold, in crystal clocks
  localparam logic [1:0] UFL_FLUSH_CYC = 2'h3;
  // timeout: four characters plus twelve bits
  localparam int UFL_TO_CHARS = 4;
  localparam int UFL_TO_BITS  = 12;
endpackage

// ---- hw/ufl_ctrl.sv ----
// Purpose: fifo setup, character format and modem control registers
// Assumes: one clk (crystal clock), async active-low nrst, fifo levels from datapath
// Notes:   baud arithmetic, flow engines and shifters live outside
module ufl_ctrl #(
  parameter int LVL_W = 7
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [2:0]       reg_idx,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  input  wire logic             enh_en,
  input  wire logic             auto_rts_en,
  input  wire logic             auto_rts_level,
  input  wire logic             half_duplex_en,
  input  wire logic             half_duplex_level,
  input  wire logic [LVL_W-1:0] rx_level,
  input  wire logic [LVL_W-1:0] tx_level,
  input  wire logic             tx_reloaded_low,
  input  wire logic             rx_line_active,
  input  wire logic [15:0]      bit_ticks,
  input  wire logic             ring_indicator_n,
  input  wire logic             carrier_detect_n,
  input  wire logic             tx_serial_in,
  output logic                  tx_serial,
  output logic                  rx_fifo_clear,
  output logic                  tx_fifo_clear,
  output logic                  fifo_enabled,
  output logic      [3:0]       word_bits,
  output logic      [1:0]       stop_half_bits,
  output logic                  parity_on,
  output logic                  parity_forced,
  output logic                  parity_value,
  output logic                  parity_even,
  output logic                  divisor_access,
  output logic      [7:0]       divisor_low,
  output logic      [7:0]       divisor_high,
  output logic      [7:0]       divisor_fraction,
  output logic                  dtr_n,
  output logic                  rts_n,
  output logic                  internal_out_one_n,
  output logic                  internal_out_two_n,
  output logic                  tx_irq,
  output logic                  rx_irq,
  output logic                  rx_timeout
);
  // elaboration check: level must hold 64
  if (LVL_W < 7) begin : g_chk
    $error("LVL_W too small");
  end
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0]  fifo_setup, next_fifo_setup;     // rx/tx trigger and enable
  logic [7:0]  character_format, next_character_format;
  logic [7:0]  modem_output_control, next_modem_output_control;
  logic [7:0]  scratchpad_byte, next_scratchpad_byte;
  logic [7:0]  flow_threshold_control, next_flow_threshold_control;
  logic [7:0]  fifo_trigger_level, next_fifo_trigger_level;
  logic [7:0]  next_divisor_low, next_divisor_high, next_divisor_fraction;
  logic [1:0]  rx_flush_cnt, next_rx_flush_cnt; // fifo reset hold counters
  logic [1:0]  tx_flush_cnt, next_tx_flush_cnt;
  logic [7:0]  next_rdata;
  logic        bank_sel;                        // enhanced bank selected
  logic        wr_fifo_ok;

  // bank at six and seven
  assign bank_sel   = enh_en & modem_output_control[2];
  assign wr_fifo_ok = reg_wdata[ufl_pkg::UFL_FIFO_EN];
  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_comb begin
    next_fifo_setup             = fifo_setup;
    next_character_format       = character_format;
    next_modem_output_control   = modem_output_control;
    next_scratchpad_byte        = scratchpad_byte;
    next_flow_threshold_control = flow_threshold_control;
    next_fifo_trigger_level     = fifo_trigger_level;
    next_divisor_low            = divisor_low;
    next_divisor_high           = divisor_high;
    next_divisor_fraction       = divisor_fraction;
    next_rx_flush_cnt           = (rx_flush_cnt != 2'h0) ? rx_flush_cnt - 2'h1 : 2'h0;
    next_tx_flush_cnt           = (tx_flush_cnt != 2'h0) ? tx_flush_cnt - 2'h1 : 2'h0;
    // self-clear reset bits once hold done
    if (rx_flush_cnt == 2'h1) begin
      next_fifo_setup[ufl_pkg::UFL_RX_RST] = 1'b0;
    end
    if (tx_flush_cnt == 2'h1) begin
      next_fifo_setup[ufl_pkg::UFL_TX_RST] = 1'b0;
    end
    if (reg_wr) begin
      unique case (reg_idx)
        ufl_pkg::UFL_IDX_DATA: begin
          if (character_format[ufl_pkg::UFL_DIV_SEL]) begin
            next_divisor_low = reg_wdata;
          end
        end
        ufl_pkg::UFL_IDX_DIVHI: begin
          if (character_format[ufl_pkg::UFL_DIV_SEL]) begin
            next_divisor_high = reg_wdata;
          end
        end
        ufl_pkg::UFL_IDX_FIFO: begin
          if (character_format[ufl_pkg::UFL_DIV_SEL]) begin
            next_divisor_fraction = reg_wdata;
          end else if (wr_fifo_ok) begin
            next_fifo_setup[0]   = 1'b1;
            next_fifo_setup[7:6] = reg_wdata[7:6];
            next_fifo_setup[3]   = 1'b0;
            if (enh_en) begin
              next_fifo_setup[5:4] = reg_wdata[5:4];
            end
            if (reg_wdata[ufl_pkg::UFL_RX_RST]) begin
              next_fifo_setup[ufl_pkg::UFL_RX_RST] = 1'b1;
              next_rx_flush_cnt = ufl_pkg::UFL_FLUSH_CYC;
            end
            if (reg_wdata[ufl_pkg::UFL_TX_RST]) begin
              next_fifo_setup[ufl_pkg::UFL_TX_RST] = 1'b1;
              next_tx_flush_cnt = ufl_pkg::UFL_FLUSH_CYC;
            end
          end else begin
            // fifo enable cleared: disable, others ignored
            next_fifo_setup[0] = 1'b0;
          end
        end
        ufl_pkg::UFL_IDX_FMT:   next_character_format = reg_wdata;
        ufl_pkg::UFL_IDX_MODEM: next_modem_output_control = reg_wdata;
        ufl_pkg::UFL_IDX_STAT6: begin
          if (bank_sel) begin
            next_flow_threshold_control = reg_wdata;
          end
        end
        ufl_pkg::UFL_IDX_STAT7: begin
          if (bank_sel) begin
            next_fifo_trigger_level = reg_wdata;
          end else begin
            next_scratchpad_byte = reg_wdata;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fifo_setup             <= ufl_pkg::UFL_ZERO;
      character_format       <= ufl_pkg::UFL_FMT_RST;
      modem_output_control   <= ufl_pkg::UFL_MODEM_RST;
      scratchpad_byte        <= ufl_pkg::UFL_SCR_RST;
      flow_threshold_control <= ufl_pkg::UFL_ZERO;
      fifo_trigger_level     <= ufl_pkg::UFL_ZERO;
      divisor_low            <= ufl_pkg::UFL_ZERO;
      divisor_high           <= ufl_pkg::UFL_ZERO;
      divisor_fraction       <= ufl_pkg::UFL_ZERO;
      rx_flush_cnt           <= 2'h0;
      tx_flush_cnt           <= 2'h0;
    end else begin
      fifo_setup             <= next_fifo_setup;
      character_format       <= next_character_format;
      modem_output_control   <= next_modem_output_control;
      scratchpad_byte        <= next_scratchpad_byte;
      flow_threshold_control <= next_flow_threshold_control;
      fifo_trigger_level     <= next_fifo_trigger_level;
      divisor_low            <= next_divisor_low;
      divisor_high           <= next_divisor_high;
      divisor_fraction       <= next_divisor_fraction;
      rx_flush_cnt           <= next_rx_flush_cnt;
      tx_flush_cnt           <= next_tx_flush_cnt;
    end
  end

  // ------------------------------------------------------------
  // modem inputs: three-flop synchronisers
  // ------------------------------------------------------------
  logic [2:0] ri_sync, cd_sync;
  logic       ri_state, cd_state, next_ri_state, next_cd_state;
  always_comb begin
    next_ri_state = (ri_sync[1] == ri_sync[2]) ? ri_sync[2] : ri_state;
    next_cd_state = (cd_sync[1] == cd_sync[2]) ? cd_sync[2] : cd_state;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ri_sync  <= 3'h7;
      cd_sync  <= 3'h7;
      ri_state <= 1'b1;
      cd_state <= 1'b1;
    end else begin
      ri_sync  <= {ri_sync[1:0], ring_indicator_n};
      cd_sync  <= {cd_sync[1:0], carrier_detect_n};
      ri_state <= next_ri_state;
      cd_state <= next_cd_state;
    end
  end

  // ------------------------------------------------------------
  // triggers, interrupts, receive timeout
  // ------------------------------------------------------------
  logic [LVL_W-1:0] tx_trig, rx_trig, tx_space;
  logic [21:0]      to_cnt, next_to_cnt, to_limit;
  logic [3:0]       frame_bits;
  always_comb begin
    // reset defaults give trigger of one
    tx_trig = LVL_W'(1);
    rx_trig = LVL_W'(1);
    if (fifo_setup[0]) begin
      unique case (fifo_setup[5:4])
        2'h0: tx_trig = LVL_W'(8);
        2'h1: tx_trig = LVL_W'(16);
        2'h2: tx_trig = LVL_W'(32);
        2'h3: tx_trig = LVL_W'(56);
      endcase
      unique case (fifo_setup[7:6])
        2'h0: rx_trig = LVL_W'(8);
        2'h1: rx_trig = LVL_W'(16);
        2'h2: rx_trig = LVL_W'(56);
        2'h3: rx_trig = LVL_W'(60);
      endcase
    end
    tx_space   = LVL_W'(64) - tx_level;
    // bits per frame: start, data, parity, stop
    frame_bits = 4'(1 + 5 + character_format[1:0] + character_format[3] + 1 + character_format[2]);
    to_limit   = 22'(({16'h0, frame_bits} * ufl_pkg::UFL_TO_CHARS + ufl_pkg::UFL_TO_BITS) * bit_ticks);
    next_to_cnt = 22'h0;
    if (rx_level != '0 && !rx_line_active && !reg_rd && to_cnt < to_limit) begin
      next_to_cnt = to_cnt + 22'h1;
    end else if (rx_level != '0 && !rx_line_active && !reg_rd) begin
      next_to_cnt = to_cnt;
    end
  end
  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  logic pin_tx, pin_rts;
  always_comb begin
    pin_tx  = character_format[ufl_pkg::UFL_BREAK] ? 1'b0 : tx_serial_in;
    pin_rts = ~modem_output_control[1];
    if (half_duplex_en) begin
      pin_rts = half_duplex_level;
    end else if (auto_rts_en) begin
      pin_rts = auto_rts_level;
    end
    next_rdata = ufl_pkg::UFL_ZERO;
    unique case (reg_idx)
      ufl_pkg::UFL_IDX_DATA:  next_rdata = character_format[7] ? divisor_low : ufl_pkg::UFL_ZERO;
      ufl_pkg::UFL_IDX_DIVHI: next_rdata = character_format[7] ? divisor_high : ufl_pkg::UFL_ZERO;
      ufl_pkg::UFL_IDX_FIFO:  next_rdata = character_format[7] ? divisor_fraction : ufl_pkg::UFL_ZERO;
      ufl_pkg::UFL_IDX_FMT:   next_rdata = character_format;
      ufl_pkg::UFL_IDX_MODEM: next_rdata = modem_output_control;
      ufl_pkg::UFL_IDX_STAT6: begin
        if (bank_sel) begin
          next_rdata = flow_threshold_control;
        end else if (modem_output_control[ufl_pkg::UFL_LOOP]) begin
          next_rdata = {modem_output_control[3], modem_output_control[2],
                        modem_output_control[0], modem_output_control[1], 4'h0};
        end else begin
          next_rdata = {~cd_state, ~ri_state, 6'h0};
        end
      end
      ufl_pkg::UFL_IDX_STAT7: next_rdata = bank_sel ? fifo_trigger_level : scratchpad_byte;
      default: next_rdata = ufl_pkg::UFL_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata          <= ufl_pkg::UFL_ZERO;
      to_cnt             <= 22'h0;
      tx_serial          <= 1'b1;
      rx_fifo_clear      <= 1'b0;
      tx_fifo_clear      <= 1'b0;
      fifo_enabled       <= 1'b0;
      word_bits          <= 4'h6;
      stop_half_bits     <= 2'h2;
      parity_on          <= 1'b0;
      parity_forced      <= 1'b0;
      parity_value       <= 1'b0;
      parity_even        <= 1'b0;
      divisor_access     <= 1'b0;
      dtr_n              <= 1'b1;
      rts_n              <= 1'b1;
      internal_out_one_n <= 1'b1;
      internal_out_two_n <= 1'b1;
      tx_irq             <= 1'b0;
      rx_irq             <= 1'b0;
      rx_timeout         <= 1'b0;
    end else begin
      reg_rdata          <= next_rdata;
      to_cnt             <= next_to_cnt;
      tx_serial          <= pin_tx;
      rx_fifo_clear      <= next_rx_flush_cnt != 2'h0;
      tx_fifo_clear      <= next_tx_flush_cnt != 2'h0;
      fifo_enabled       <= fifo_setup[0];
      word_bits          <= 4'(5 + character_format[1:0]);
      stop_half_bits     <= !character_format[ufl_pkg::UFL_STOP] ? 2'h2 :
                            (character_format[1:0] == 2'h0) ? 2'h3 : 2'h0;
      parity_on          <= character_format[ufl_pkg::UFL_PAR_EN];
      parity_forced      <= character_format[ufl_pkg::UFL_PAR_FRC];
      parity_value       <= ~character_format[ufl_pkg::UFL_PAR_EVEN];
      parity_even        <= character_format[ufl_pkg::UFL_PAR_EVEN];
      divisor_access     <= character_format[ufl_pkg::UFL_DIV_SEL];
      dtr_n              <= ~modem_output_control[0];
      rts_n              <= pin_rts;
      internal_out_one_n <= ~modem_output_control[2];
      internal_out_two_n <= ~modem_output_control[3];
      tx_irq             <= (tx_space > tx_trig) | (tx_level == '0 && tx_reloaded_low);
      rx_irq             <= (rx_level > rx_trig) | (to_cnt == to_limit && to_limit != 22'h0);
      rx_timeout         <= to_cnt == to_limit && to_limit != 22'h0;
    end
  end
endmodule

// ---- test/ufl_ctrl_sva.sv ----
// Purpose: concurrent checks on the control block ports
// Assumes: single clock domain, writes spaced by at least four cycles
// Notes:   write effects are judged two edges after the taking edge
module ufl_ctrl_sva #(
  parameter int LVL_W = 7
) (
  input wire logic             clk,
  input wire logic             nrst,
  input wire logic             reg_wr,
  input wire logic [2:0]       reg_idx,
  input wire logic [7:0]       reg_wdata,
  input wire logic             auto_rts_en,
  input wire logic             half_duplex_en,
  input wire logic [LVL_W-1:0] tx_level,
  input wire logic             tx_reloaded_low,
  input wire logic             tx_serial,
  input wire logic             rx_fifo_clear,
  input wire logic             tx_fifo_clear,
  input wire logic             fifo_enabled,
  input wire logic [3:0]       word_bits,
  input wire logic [1:0]       stop_half_bits,
  input wire logic             parity_on,
  input wire logic             parity_even,
  input wire logic             divisor_access,
  input wire logic [7:0]       divisor_low,
  input wire logic             dtr_n,
  input wire logic             rts_n,
  input wire logic             internal_out_two_n,
  input wire logic             tx_irq,
  input wire logic             rx_irq,
  input wire logic             rx_timeout
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // write sequences
  // ----------------------------------------
  sequence s_fmt_wr;
    reg_wr && reg_idx == ufl_pkg::UFL_IDX_FMT;
  endsequence
  sequence s_setup_wr;
    reg_wr && reg_idx == ufl_pkg::UFL_IDX_FIFO && !divisor_access;
  endsequence
  sequence s_modem_wr;
    reg_wr && reg_idx == ufl_pkg::UFL_IDX_MODEM;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_rx_pulse;
    $rose(rx_fifo_clear) |-> rx_fifo_clear[*3] ##1 !rx_fifo_clear;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx clear pulse not three cycles");
  property p_tx_pulse;
    $rose(tx_fifo_clear) |-> tx_fifo_clear[*3] ##1 !tx_fifo_clear;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx clear pulse not three cycles");
  property p_rx_start;
    s_setup_wr and reg_wdata[1:0] == 2'h3 && !rx_fifo_clear |-> ##[1:2] rx_fifo_clear;
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("rx clear did not start");
  property p_setup_off;
    s_setup_wr and !reg_wdata[0] |-> ##2 !fifo_enabled && !rx_fifo_clear && !tx_fifo_clear;
  endproperty
  a_setup_off: assert property (p_setup_off) else $error("setup write without enable acted");
  property p_word;
    s_fmt_wr |-> ##2 word_bits == {2'h0, $past(reg_wdata[1:0], 2)} + 4'h5;
  endproperty
  a_word: assert property (p_word) else $error("word length wrong");
  property p_stop;
    s_fmt_wr |-> ##2 stop_half_bits == (!$past(reg_wdata[2], 2) ? 2'h2 :
                                       ($past(reg_wdata[1:0], 2) == 2'h0 ? 2'h3 : 2'h0));
  endproperty
  a_stop: assert property (p_stop) else $error("stop length wrong");
  property p_parity;
    s_fmt_wr |-> ##2 parity_on == $past(reg_wdata[3], 2) && parity_even == $past(reg_wdata[4], 2);
  endproperty
  a_parity: assert property (p_parity) else $error("parity setup wrong");
  property p_break;
    s_fmt_wr and reg_wdata[6] |-> ##2 !tx_serial[*3];
  endproperty
  a_break: assert property (p_break) else $error("break not holding line low");
  property p_dtr;
    s_modem_wr |-> ##2 dtr_n == !$past(reg_wdata[0], 2) && internal_out_two_n == !$past(reg_wdata[3], 2);
  endproperty
  a_dtr: assert property (p_dtr) else $error("modem outputs wrong");
  property p_rts;
    s_modem_wr and !auto_rts_en && !half_duplex_en ##1 !auto_rts_en && !half_duplex_en [*2]
      |-> rts_n == !$past(reg_wdata[1], 2);
  endproperty
  a_rts: assert property (p_rts) else $error("rts output wrong");
  property p_tx_empty;
    fifo_enabled && tx_level == '0 && tx_reloaded_low |-> ##[1:2] tx_irq;
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty irq missing");
  property p_rx_to;
    rx_timeout |-> ##[0:1] rx_irq;
  endproperty
  a_rx_to: assert property (p_rx_to) else $error("timeout without rx irq");
endmodule

bind ufl_ctrl ufl_ctrl_sva #(.LVL_W(LVL_W)) ufl_ctrl_sva_inst (
  .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
  .auto_rts_en(auto_rts_en), .half_duplex_en(half_duplex_en), .tx_level(tx_level),
  .tx_reloaded_low(tx_reloaded_low), .tx_serial(tx_serial), .rx_fifo_clear(rx_fifo_clear),
  .tx_fifo_clear(tx_fifo_clear), .fifo_enabled(fifo_enabled), .word_bits(word_bits),
  .stop_half_bits(stop_half_bits), .parity_on(parity_on), .parity_even(parity_even),
  .divisor_access(divisor_access), .divisor_low(divisor_low), .dtr_n(dtr_n), .rts_n(rts_n),
  .internal_out_two_n(internal_out_two_n), .tx_irq(tx_irq), .rx_irq(rx_irq), .rx_timeout(rx_timeout));

// ---- test/ufl_host_model.sv ----
// Purpose: host side of the register port
// Assumes: strobes launched just after a rising edge
// Notes:   each write is followed by idle cycles so effects settle
module ufl_host_model (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [2:0] reg_idx,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_idx = 3'h0;
    reg_wdata = 8'h00;
  end
  // one write strobe, then let it settle
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_idx <= i;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // index held until the registered answer is taken
  task automatic rd(input logic [2:0] i, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_idx <= i;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule

// ---- test/test_ufl_ctrl.sv ----
// Purpose: register sequences with expected outputs
// Assumes: 25 MHz clk, async active-low nrst
// Notes:   overrides held still around modem writes
module test_ufl_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, reg_wr, reg_rd, enh_en, auto_rts_en, auto_rts_level, half_duplex_en, half_duplex_level;
  logic tx_reloaded_low, rx_line_active, ring_indicator_n, carrier_detect_n, tx_serial_in;
  logic [2:0] reg_idx;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [6:0] rx_level, tx_level;
  logic [15:0] bit_ticks;
  logic tx_serial, rx_fifo_clear, tx_fifo_clear, fifo_enabled, parity_on, parity_forced, parity_value;
  logic parity_even, divisor_access, dtr_n, rts_n, out_one_n, out_two_n, tx_irq, rx_irq, rx_timeout;
  logic [3:0] word_bits;
  logic [1:0] stop_half_bits;
  logic [7:0] div_lo, div_hi, div_fr;
  int bad_count, checks_done, rx_hi, tx_hi;
  int rtab[4] = '{8, 16, 56, 60};
  int ttab[4] = '{8, 16, 32, 56};
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ufl_host_model ufl_host_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  ufl_ctrl #(.LVL_W(7)) ufl_ctrl_inst (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .enh_en(enh_en),
    .auto_rts_en(auto_rts_en), .auto_rts_level(auto_rts_level), .half_duplex_en(half_duplex_en),
    .half_duplex_level(half_duplex_level), .rx_level(rx_level), .tx_level(tx_level),
    .tx_reloaded_low(tx_reloaded_low), .rx_line_active(rx_line_active), .bit_ticks(bit_ticks),
    .ring_indicator_n(ring_indicator_n), .carrier_detect_n(carrier_detect_n), .tx_serial_in(tx_serial_in),
    .tx_serial(tx_serial), .rx_fifo_clear(rx_fifo_clear), .tx_fifo_clear(tx_fifo_clear),
    .fifo_enabled(fifo_enabled), .word_bits(word_bits), .stop_half_bits(stop_half_bits),
    .parity_on(parity_on), .parity_forced(parity_forced), .parity_value(parity_value),
    .parity_even(parity_even), .divisor_access(divisor_access), .divisor_low(div_lo), .divisor_high(div_hi),
    .divisor_fraction(div_fr), .dtr_n(dtr_n), .rts_n(rts_n), .internal_out_one_n(out_one_n),
    .internal_out_two_n(out_two_n), .tx_irq(tx_irq), .rx_irq(rx_irq), .rx_timeout(rx_timeout));
  // clear pulse widths
  always @(posedge clk) begin
    if (rx_fifo_clear === 1'b1) rx_hi++;
    if (tx_fifo_clear === 1'b1) tx_hi++;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  initial begin
    {nrst, enh_en, auto_rts_en, auto_rts_level, half_duplex_en, half_duplex_level, tx_reloaded_low} = '0;
    {ring_indicator_n, carrier_detect_n, tx_serial_in, rx_line_active} = 4'hF;
    rx_level = 7'h00;
    tx_level = 7'h00;
    bit_ticks = 16'hFFFF;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    settle();
    // reset state
    chk("word", 8'h06, word_bits);
    chk("stop", 8'h00, stop_half_bits);
    chk("par", 8'h01, parity_on);
    chk("even", 8'h01, parity_even);
    chk("dtr", 8'h01, dtr_n);
    chk("op2", 8'h01, out_two_n);
    ufl_host_model_inst.rd(3'h7, d);
    chk("scratch", 8'hFF, d);
    $display("test reset done");
    // word lengths with long stop
    for (int w = 0; w < 4; w++) begin
      ufl_host_model_inst.wr(3'h3, {6'h01, w[1:0]});
      chk("word", 8'h05 + 8'(w), word_bits);
      chk("stop", (w == 0) ? 8'h03 : 8'h00, stop_half_bits);
    end
    // every parity selection
    for (int p = 0; p < 8; p++) begin
      ufl_host_model_inst.wr(3'h3, {2'h0, p[2:0], 3'h3});
      chk("par", {7'h00, p[0]}, parity_on);
      chk("even", {7'h00, p[1]}, parity_even);
      if (p[0] && p[2]) chk("force", {7'h00, !p[1]}, parity_value);
      chk("frc", {7'h00, p[2]}, parity_forced);
    end
    chk("stop", 8'h02, stop_half_bits);
    // break holds line low until cleared
    ufl_host_model_inst.wr(3'h3, 8'h40);
    chk("brk", 8'h00, tx_serial);
    ufl_host_model_inst.wr(3'h3, 8'h00);
    chk("brk", 8'h01, tx_serial);
    // divisor latches behind the data indices
    ufl_host_model_inst.wr(3'h3, 8'h80);
    ufl_host_model_inst.wr(3'h0, 8'h34);
    ufl_host_model_inst.wr(3'h1, 8'h12);
    ufl_host_model_inst.wr(3'h2, 8'h05);
    chk("dlo", 8'h34, div_lo);
    chk("dhi", 8'h12, div_hi);
    chk("dfr", 8'h05, div_fr);
    chk("dacc", 8'h01, divisor_access);
    ufl_host_model_inst.wr(3'h3, 8'h00);
    ufl_host_model_inst.wr(3'h0, 8'h99);
    chk("dlo", 8'h34, div_lo);
    $display("test format done");
    // fifo setup: enable gate, clears, reserved bit
    ufl_host_model_inst.wr(3'h2, 8'h06);
    chk("fen", 8'h00, fifo_enabled);
    rx_hi = 0;
    tx_hi = 0;
    ufl_host_model_inst.wr(3'h2, 8'h0B);
    settle();
    chk("rxclr", 8'h03, 8'(rx_hi));
    chk("txclr", 8'h00, 8'(tx_hi));
    ufl_host_model_inst.wr(3'h2, 8'h05);
    settle();
    chk("txclr", 8'h03, 8'(tx_hi));
    chk("fen", 8'h01, fifo_enabled);
    // modem outputs and overrides
    ufl_host_model_inst.wr(3'h4, 8'h0F);
    chk("dtr", 8'h00, dtr_n);
    chk("rts", 8'h00, rts_n);
    chk("op2", 8'h00, out_two_n);
    chk("op1", 8'h00, out_one_n);
    auto_rts_en <= 1'b1;
    auto_rts_level <= 1'b1;
    settle();
    chk("rts", 8'h01, rts_n);
    half_duplex_en <= 1'b1;
    settle();
    chk("rts", 8'h00, rts_n);
    {auto_rts_en, half_duplex_en} <= 2'h0;
    // banked indices six and seven
    ufl_host_model_inst.wr(3'h7, 8'h5A);
    enh_en <= 1'b1;
    ufl_host_model_inst.wr(3'h7, 8'h33);
    ufl_host_model_inst.rd(3'h7, d);
    chk("tlr", 8'h33, d);
    ufl_host_model_inst.wr(3'h6, 8'hC7);
    ufl_host_model_inst.rd(3'h6, d);
    chk("tcr", 8'hC7, d);
    enh_en <= 1'b0;
    ring_indicator_n <= 1'b0;
    ufl_host_model_inst.rd(3'h7, d);
    chk("scratch", 8'h5A, d);
    ufl_host_model_inst.rd(3'h6, d);
    chk("msr", 8'h01, {6'h00, d[7:6]});
    ufl_host_model_inst.wr(3'h4, 8'h1C);
    ufl_host_model_inst.rd(3'h6, d);
    chk("msr", 8'h03, {6'h00, d[7:6]});
    ufl_host_model_inst.wr(3'h4, 8'h00);
    $display("test modem done");
    // trigger levels, just at and just above
    enh_en <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      ufl_host_model_inst.wr(3'h2, {c[1:0], c[1:0], 4'h1});
      rx_level <= 7'(rtab[c]);
      tx_level <= 7'(64 - ttab[c]);
      settle();
      chk("rxirq", 8'h00, rx_irq);
      chk("txirq", 8'h00, tx_irq);
      rx_level <= 7'(rtab[c] + 1);
      tx_level <= 7'(63 - ttab[c]);
      settle();
      chk("rxirq", 8'h01, rx_irq);
      chk("txirq", 8'h01, tx_irq);
    end
    tx_level <= 7'h00;
    tx_reloaded_low <= 1'b1;
    settle();
    chk("txirq", 8'h01, tx_irq);
    // idle timeout: 5 data bits, one stop, 4 clocks a bit: 160 clocks
    ufl_host_model_inst.wr(3'h3, 8'h00);
    ufl_host_model_inst.wr(3'h2, 8'h01);
    rx_level <= 7'h01;
    bit_ticks <= 16'h0004;
    rx_line_active <= 1'b0;
    repeat (140) @(posedge clk);
    chk("tmo", 8'h00, rx_timeout);
    repeat (60) @(posedge clk);
    chk("tmo", 8'h01, rx_timeout);
    chk("rxirq", 8'h01, rx_irq);
    $display("test triggers done");
    complete_run();
  end
endmodule
